// >>> design/umls_line_status.sv
`timescale 1ns/100ps
`include "umls_cfg.svh"
// Contract
// - queue error summary, zero in compatibility mode
// - transmitter-empty written by processor unless double-buffered
// - holding-empty set on read or empty queue
// - host holding-empty delayed by timer, shadow not
// - processor error writes shadowed, copied on write
// - queued error flags visible at queue head
// - shadow clears on write, register on status read
// - error flags accumulate over successive host reads
// - overrun on second write or full queue
// - data-ready immediate or after receive timer
// - undelayed data-ready shadow, both clear when empty
// - interrupt enable bits 7..4 read zero
// - modem status interrupt when enabled
// - line status interrupt on bits 1..4
// - holding-empty interrupt when enabled
// - received-data interrupt on ready or timeout
// - enable register host read-write, processor read-only
// - host holding write withdraws interrupt quickly
// - holding-empty interrupt at least two cycles after stop
// - logic frozen in power-down, interrupt line dropped

// ----------------------------------------------------------------
// receive queue
// ----------------------------------------------------------------
module umls_fifo #(
   parameter int WIDTH = 11,
   parameter int DEPTH = 32
) (
   // clock and reset
   input  wire logic                       clk,
   input  wire logic                       sys_rst,
   // fill side
   input  wire logic                       in_valid,
   output logic                            in_ready,
   input  wire logic [WIDTH-1:0]           in_data,
   // drain side
   output logic                            out_valid,
   input  wire logic                       out_ready,
   output logic [WIDTH-1:0]                out_data,
   // fill level
   output logic [$clog2(DEPTH):0]          count
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0]   cnt;
   } umls_fifo_st_s;

   umls_fifo_st_s    st_q;
   umls_fifo_st_s    st_d;
   logic [WIDTH-1:0] mem [DEPTH];
   logic             do_wr;
   logic             do_rd;

   assign in_ready  = (st_q.cnt != (AW+1)'(DEPTH));
   assign out_valid = (st_q.cnt != '0);
   assign out_data  = mem[st_q.rp];
   assign count     = st_q.cnt;
   assign do_wr     = in_valid & in_ready;
   assign do_rd     = out_valid & out_ready;

   // pointer and level update
   always_comb begin
      st_d = st_q;
      if (do_wr) begin
         st_d.wp = st_q.wp + 1'b1;
      end
      if (do_rd) begin
         st_d.rp = st_q.rp + 1'b1;
      end
      case ({do_wr, do_rd})
         2'b10:   st_d.cnt = st_q.cnt + 1'b1;
         2'b01:   st_d.cnt = st_q.cnt - 1'b1;
         default: st_d.cnt = st_q.cnt;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // storage has no reset; only written slots are ever read
   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem[st_q.wp] <= in_data;
      end
   end
endmodule

// ----------------------------------------------------------------
// line status and interrupt enable
// ----------------------------------------------------------------
module umls_line_status #(
   parameter int DEPTH = 32
) (
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    sys_rst,
   // operating options and power state
   input  wire umls_pkg::umls_mode_s    mode,
   input  wire logic                    power_down,
   // host bus
   input  wire umls_pkg::umls_pc_req_s  pc_req,
   output logic [7:0]                   pc_rdata,
   // processor bus
   input  wire umls_pkg::umls_mpu_req_s mpu_req,
   output logic [7:0]                   mpu_rdata,
   // transmit, timer and modem status
   input  wire logic                    tx_queue_empty,
   input  wire logic                    tx_shift_idle,
   input  wire logic                    tx_stop,
   input  wire logic                    tx_timer_tick,
   input  wire logic                    rx_timer_tick,
   input  wire logic                    rx_timeout,
   input  wire logic [3:0]              modem_status,
   // host interrupt and queue back-pressure
   output logic                         host_irq,
   output logic                         rx_wr_ready
);
   import umls_pkg::*;

   localparam int CW = $clog2(DEPTH) + 1;

   typedef struct packed {
      logic [3:0]    host_irq_enable;
      logic [2:0]    err_sh;
      logic [2:0]    err_lsr;
      logic          ovr;
      logic          dr;
      logic          tx_holding_empty_flag_sh;
      logic          tx_holding_empty_flag_pc;
      logic          transmitter_empty_flag;
      logic [CW-1:0] err_cnt;
      logic [1:0]    hold;
      logic          irq;
      logic [7:0]    pc_rdata;
      logic [7:0]    mpu_rdata;
   } umls_st_s;

   umls_st_s      st_q;
   umls_st_s      st_d;
   umls_rx_word_s q_in;
   umls_rx_word_s q_head;
   logic          q_full_ready;
   logic          q_valid;
   logic [CW-1:0] q_count;
   logic          act;
   logic          pc_lsr_rd;
   logic          pc_data_rd;
   logic          pc_data_wr;
   logic          pc_ier_wr;
   logic          mpu_data_wr;
   logic          mpu_data_rd;
   logic          mpu_lsr_wr;
   logic          push;
   logic          pop;
   logic          ovr_evt;
   logic          has_next;
   logic [2:0]    err_vis;
   logic [7:0]    lsr_pc;
   logic [7:0]    lsr_mpu;
   logic          hold_done;

   // every access is ignored while the processor sleeps
   assign act         = ~power_down;
   assign pc_lsr_rd   = act & pc_req.rd & (pc_req.addr == `UMLS_PC_LSR_OFS);
   assign pc_data_rd  = act & pc_req.rd & (pc_req.addr == `UMLS_PC_DATA_OFS);
   assign pc_data_wr  = act & pc_req.wr & (pc_req.addr == `UMLS_PC_DATA_OFS);
   assign pc_ier_wr   = act & pc_req.wr & (pc_req.addr == `UMLS_PC_IER_OFS);
   assign mpu_data_wr = act & mpu_req.wr & (mpu_req.addr == `UMLS_MPU_DATA_ADR);
   assign mpu_data_rd = act & mpu_req.rd & (mpu_req.addr == `UMLS_MPU_DATA_ADR);
   assign mpu_lsr_wr  = act & mpu_req.wr & (mpu_req.addr == `UMLS_MPU_LSR_ADR);

   // compatibility mode holds a single byte; the queue gives full depth
   assign rx_wr_ready = mode.fifo_mode ? q_full_ready : (q_count == '0);
   assign push        = mpu_data_wr & rx_wr_ready;
   assign ovr_evt     = mpu_data_wr & ~rx_wr_ready;  // offending byte dropped
   assign pop         = pc_data_rd & q_valid;
   assign q_in.err    = st_q.err_sh;  // shadow travels with the byte
   assign q_in.data   = mpu_req.wdata;

   umls_fifo #(
      .WIDTH ($bits(umls_rx_word_s)),
      .DEPTH (DEPTH)
   ) u_rxq (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .in_valid  (push),
      .in_ready  (q_full_ready),
      .in_data   (q_in),
      .out_valid (q_valid),
      .out_ready (pop),
      .out_data  (q_head),
      .count     (q_count)
   );

   // data still present after this edge
   assign has_next = push | (q_count > CW'(1)) | ((q_count == CW'(1)) & ~pop);

   // head flags show only in queue mode, and only at the head
   assign err_vis = st_q.err_lsr |
                    ((mode.fifo_mode & q_valid) ? q_head.err : 3'b000);

   // host view uses delayed flags, processor view the shadows
   always_comb begin
      lsr_pc                               = 8'h00;
      lsr_pc[`UMLS_LSR_DR]                 = st_q.dr;
      lsr_pc[`UMLS_LSR_OE]                 = st_q.ovr;
      lsr_pc[`UMLS_LSR_BI:`UMLS_LSR_PE]    = err_vis;
      lsr_pc[`UMLS_LSR_TX_HOLDING_EMPTY_FLAG]               = st_q.tx_holding_empty_flag_pc;
      lsr_pc[`UMLS_LSR_TRANSMITTER_EMPTY_FLAG]               = st_q.transmitter_empty_flag;
      lsr_pc[`UMLS_LSR_RQERR]              = mode.fifo_mode & (st_q.err_cnt != '0);
      lsr_mpu                              = lsr_pc;
      lsr_mpu[`UMLS_LSR_DR]                = q_valid;  // undelayed
      lsr_mpu[`UMLS_LSR_TX_HOLDING_EMPTY_FLAG]              = st_q.tx_holding_empty_flag_sh;  // undelayed
   end

   assign hold_done = (st_q.hold == 2'd0);

   // next state of all flags and read data
   always_comb begin
      st_d = st_q;
      // enable register, upper nibble never stored
      if (pc_ier_wr) begin
         st_d.host_irq_enable = pc_req.wdata[3:0];
      end
      // error shadows: written by the processor, cleared by a byte write
      if (mpu_lsr_wr) begin
         st_d.err_sh = mpu_req.wdata[`UMLS_LSR_BI:`UMLS_LSR_PE];
      end else if (mpu_data_wr) begin
         st_d.err_sh = 3'b000;
      end
      // visible errors: new causes win over the clearing status read
      st_d.err_lsr = pc_lsr_rd ? 3'b000 : st_q.err_lsr;
      if (push & ~mode.fifo_mode) begin
         st_d.err_lsr = st_d.err_lsr | st_q.err_sh;
      end
      if (pop & mode.fifo_mode) begin
         st_d.err_lsr = st_d.err_lsr | q_head.err;
      end
      // count of queued bytes that carry any error
      st_d.err_cnt = st_q.err_cnt + CW'(push & (|st_q.err_sh))
                                  - CW'(pop & (|q_head.err));
      // overrun: set wins over the status-read clear
      st_d.ovr = ovr_evt | (st_q.ovr & ~pc_lsr_rd);
      // host data-ready waits for the receive timer when enabled
      st_d.dr = has_next & (st_q.dr | ~mode.rx_timer_en | rx_timer_tick);
      // holding-empty shadow
      if (pc_data_wr) begin
         st_d.tx_holding_empty_flag_sh = 1'b0;
      end else if (mode.fifo_mode ? tx_queue_empty : mpu_data_rd) begin
         st_d.tx_holding_empty_flag_sh = 1'b1;
      end
      // host copy trails the shadow by the transmit timer
      if (pc_data_wr | ~st_q.tx_holding_empty_flag_sh) begin
         st_d.tx_holding_empty_flag_pc = 1'b0;
      end else if (~mode.tx_timer_en | tx_timer_tick) begin
         st_d.tx_holding_empty_flag_pc = 1'b1;
      end
      // transmitter-empty: processor-owned unless double buffering
      if (mode.double_buf) begin
         st_d.transmitter_empty_flag = st_q.tx_holding_empty_flag_sh & tx_shift_idle;
      end else if (mpu_lsr_wr) begin
         st_d.transmitter_empty_flag = mpu_req.wdata[`UMLS_LSR_TRANSMITTER_EMPTY_FLAG];
      end
      // hold-off after a stop bit before the empty interrupt may fire
      if (tx_stop) begin
         st_d.hold = 2'(`UMLS_TSTI_CYC);
      end else if (~hold_done) begin
         st_d.hold = st_q.hold - 2'd1;
      end
      // single request line, or of every enabled cause
      st_d.irq = (st_q.host_irq_enable[`UMLS_IER_MSR] & (|modem_status))
               | (st_q.host_irq_enable[`UMLS_IER_RLS] & (|lsr_pc[`UMLS_LSR_BI:`UMLS_LSR_OE]))
               | (st_q.host_irq_enable[`UMLS_IER_TX_HOLDING_EMPTY_FLAG] & st_d.tx_holding_empty_flag_pc & hold_done & ~tx_stop)
               | (st_q.host_irq_enable[`UMLS_IER_RDA] & (st_q.dr | rx_timeout));
      // registered read data
      st_d.pc_rdata = `UMLS_RDATA_RST;
      if (act & pc_req.rd) begin
         case (pc_req.addr)
            `UMLS_PC_DATA_OFS: st_d.pc_rdata = q_valid ? q_head.data : 8'h00;
            `UMLS_PC_IER_OFS:  st_d.pc_rdata = {4'h0, st_q.host_irq_enable};
            `UMLS_PC_LSR_OFS:  st_d.pc_rdata = lsr_pc;
            default:           st_d.pc_rdata = 8'h00;
         endcase
      end
      st_d.mpu_rdata = `UMLS_RDATA_RST;
      if (act & mpu_req.rd) begin
         case (mpu_req.addr)
            `UMLS_MPU_IER_ADR: st_d.mpu_rdata = {4'h0, st_q.host_irq_enable};
            `UMLS_MPU_LSR_ADR: st_d.mpu_rdata = lsr_mpu;
            default:           st_d.mpu_rdata = 8'h00;
         endcase
      end
      // frozen while asleep; the interrupt line is dropped
      if (power_down) begin
         st_d     = st_q;
         st_d.irq = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_q           <= '0;
         st_q.host_irq_enable       <= `UMLS_IER_RST;
         st_q.pc_rdata  <= `UMLS_RDATA_RST;
         st_q.mpu_rdata <= `UMLS_RDATA_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign host_irq  = st_q.irq;
   assign pc_rdata  = st_q.pc_rdata;
   assign mpu_rdata = st_q.mpu_rdata;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   AST_RQERR_COMPAT: assert property (
      !mode.fifo_mode |-> !lsr_pc[`UMLS_LSR_RQERR])
      else $error("queue error summary set in compatibility mode");

   AST_OVR_SET: assert property (
      ovr_evt |=> st_q.ovr && (q_count <= $past(q_count)))
      else $error("overrun not flagged or byte stored");

   AST_OVR_CLR: assert property (
      pc_lsr_rd && !ovr_evt |=> !st_q.ovr)
      else $error("overrun not cleared by status read");

   AST_DR_IMMED: assert property (
      push && !mode.rx_timer_en && !power_down |=> st_q.dr && q_valid)
      else $error("data ready not immediate");

   AST_DR_EMPTY: assert property (
      q_count == '0 |-> !st_q.dr && !lsr_mpu[`UMLS_LSR_DR])
      else $error("data ready set with empty queue");

   AST_IER_RSVD: assert property (
      pc_req.rd && pc_req.addr == `UMLS_PC_IER_OFS |=> pc_rdata[7:4] == 4'h0)
      else $error("reserved enable bits not zero");

   AST_TX_HOLDING_EMPTY_FLAG_CLR: assert property (
      pc_data_wr |=> !st_q.tx_holding_empty_flag_sh && !st_q.tx_holding_empty_flag_pc)
      else $error("holding-empty not cleared by host write");

   AST_TX_HOLDING_EMPTY_FLAG_SET: assert property (
      mpu_data_rd && !mode.fifo_mode && !pc_data_wr |=> st_q.tx_holding_empty_flag_sh)
      else $error("holding-empty shadow not set on processor read");

   AST_IRQ_WITHDRAW: assert property (
      pc_data_wr && st_q.host_irq_enable == 4'h2 && !rx_timeout ##1 st_q.host_irq_enable == 4'h2 |=> !host_irq)
      else $error("empty interrupt not withdrawn in time");

   AST_STOP_HOLD: assert property (
      tx_stop && st_q.host_irq_enable == 4'h2 ##1 st_q.host_irq_enable == 4'h2 |-> !host_irq ##1 !host_irq)
      else $error("empty interrupt too soon after stop");

   AST_PD_QUIET: assert property (
      power_down |=> !host_irq && $stable(st_q.host_irq_enable))
      else $error("activity during power-down");

   COV_OVERRUN:   cover property (ovr_evt ##1 pc_lsr_rd);
   COV_QUEUE_ERR: cover property (mode.fifo_mode && lsr_pc[`UMLS_LSR_RQERR] ##[1:8] pop);
   COV_TX_HOLDING_EMPTY_FLAG_IRQ:  cover property (tx_stop ##[3:10] host_irq);
endmodule

// >>> design/umls_cfg.svh
`ifndef UMLS_CFG_SVH
`define UMLS_CFG_SVH

// host-side register offsets
`define UMLS_PC_DATA_OFS   3'h0
`define UMLS_PC_IER_OFS    3'h1
`define UMLS_PC_LSR_OFS    3'h5

// processor-side addresses, low byte only
`define UMLS_MPU_DATA_ADR  8'hF0
`define UMLS_MPU_IER_ADR   8'hF1
`define UMLS_MPU_LSR_ADR   8'hF5

// line status bit positions
`define UMLS_LSR_DR        0
`define UMLS_LSR_OE        1
`define UMLS_LSR_PE        2
`define UMLS_LSR_BI        4
`define UMLS_LSR_TX_HOLDING_EMPTY_FLAG      5
`define UMLS_LSR_TRANSMITTER_EMPTY_FLAG      6
`define UMLS_LSR_RQERR     7

// interrupt enable bit positions
`define UMLS_IER_RDA       0
`define UMLS_IER_TX_HOLDING_EMPTY_FLAG      1
`define UMLS_IER_RLS       2
`define UMLS_IER_MSR       3

// reset values
`define UMLS_IER_RST       4'h0
`define UMLS_RDATA_RST     8'h00

// stop-to-interrupt least delay, in processor clock cycles
`define UMLS_TSTI_CYC      2

`endif

// >>> design/umls_pkg.sv
package umls_pkg;

   // host bus request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [2:0] addr;
      logic [7:0] wdata;
   } umls_pc_req_s;

   // processor bus request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } umls_mpu_req_s;

   // operating options
   typedef struct packed {
      logic fifo_mode;
      logic double_buf;
      logic rx_timer_en;
      logic tx_timer_en;
   } umls_mode_s;

   // one queued received byte with its error flags
   typedef struct packed {
      logic [2:0] err;
      logic [7:0] data;
   } umls_rx_word_s;

endpackage

// >>> tb/umls_host_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// host bus model
// ----------------------------------------------------------------
module umls_host_model (
   // clock
   input  wire logic              clk,
   // host bus
   output umls_pkg::umls_pc_req_s pc_req,
   input  wire logic [7:0]        pc_rdata
);
   import umls_pkg::*;

   // idle bus until the first call
   initial pc_req = '0;

   // request launched after an edge, held through the taking edge
   task automatic host_wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      pc_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      pc_req <= '0;
   endtask

   // read data is registered, so it is caught just after the taking edge
   task automatic host_rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      pc_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk);
      pc_req <= '0;
      #1 d = pc_rdata;
   endtask
endmodule

// >>> tb/umls_line_status_tb.sv
`timescale 1ns/100ps
`include "umls_cfg.svh"
module umls_line_status_tb;
   import umls_pkg::*;

   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic          clk;
   logic          sys_rst;
   umls_mode_s    mode;
   logic          power_down;
   umls_pc_req_s  pc_req;
   logic [7:0]    pc_rdata;
   umls_mpu_req_s mpu_req;
   logic [7:0]    mpu_rdata;
   logic          rx_timeout;
   logic          tx_stop;
   logic [3:0]    modem_status;
   logic          host_irq;
   logic          rx_wr_ready;
   logic [7:0]    rd;
   int            n_fail;
   int            checks_done;
   int            cycles;

   // ----------------------------------------------------------------
   // design and host model
   // ----------------------------------------------------------------
   umls_line_status #(.DEPTH(32)) DUT (
      .clk(clk), .sys_rst(sys_rst), .mode(mode), .power_down(power_down),
      .pc_req(pc_req), .pc_rdata(pc_rdata), .mpu_req(mpu_req), .mpu_rdata(mpu_rdata),
      .tx_queue_empty(1'b0), .tx_shift_idle(1'b0), .tx_stop(tx_stop),
      .tx_timer_tick(1'b0), .rx_timer_tick(1'b0), .rx_timeout(rx_timeout),
      .modem_status(modem_status), .host_irq(host_irq), .rx_wr_ready(rx_wr_ready)
   );

   umls_host_model HOST (.clk(clk), .pc_req(pc_req), .pc_rdata(pc_rdata));

   // free-running clock, 10 ns period
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // hang guard: the whole sequence needs well under 1000 cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         $display("[ERR] %0t timeout", $time);
         n_fail = n_fail + 1;
         end_of_test();
      end
   end

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done = checks_done + 1;
      if (got !== exp) begin
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
         n_fail = n_fail + 1;
      end
   endtask

   task automatic mpu_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      mpu_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      mpu_req <= '0;
   endtask

   task automatic mpu_rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      mpu_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk);
      mpu_req <= '0;
      #1 d = mpu_rdata;
   endtask

   // irq is registered from flags; give it a few edges to settle
   // returns on an edge so that the next stimulus lands on it
   task automatic irq_is(input logic exp);
      repeat (3) @(posedge clk);
      #1 chk({7'h00, host_irq}, {7'h00, exp});
      @(posedge clk);
   endtask

   // reset with a fresh static mode, held 10 cycles
   task automatic restart(input logic fifo);
      @(posedge clk);
      sys_rst <= 1'b1;
      mode    <= '{fifo_mode: fifo, double_buf: 1'b0, rx_timer_en: 1'b0, tx_timer_en: 1'b0};
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      sys_rst = 1'b1;
      mode = '0;
      power_down = 1'b0;
      mpu_req = '0;
      rx_timeout = 1'b0;
      tx_stop = 1'b0;
      modem_status = 4'h0;
      n_fail = 0;
      checks_done = 0;
      cycles = 0;
      restart(1'b0);

      // enable register: reserved bits, processor read-only
      HOST.host_rd(3'h1, rd); chk(rd, 8'h00);
      HOST.host_wr(3'h1, 8'hFF);
      HOST.host_rd(3'h1, rd); chk(rd, 8'h0F);
      mpu_wr(8'hF1, 8'h00);
      mpu_rd(8'hF1, rd); chk(rd, 8'h0F);
      HOST.host_wr(3'h1, 8'h04);
      $display("test enable register done");

      // errors via shadow, status read clears, overrun
      mpu_wr(8'hF5, 8'h54);
      HOST.host_rd(3'h5, rd); chk(rd, 8'h40);
      mpu_wr(8'hF0, 8'hA5);
      irq_is(1'b1);
      HOST.host_rd(3'h5, rd); chk(rd, 8'h55);
      HOST.host_rd(3'h5, rd); chk(rd, 8'h41);
      irq_is(1'b0);
      mpu_wr(8'hF0, 8'h5A);
      HOST.host_rd(3'h5, rd); chk(rd, 8'h43);
      HOST.host_rd(3'h0, rd); chk(rd, 8'hA5);
      HOST.host_rd(3'h5, rd); chk(rd, 8'h40);
      mpu_wr(8'hF0, 8'h77);
      HOST.host_rd(3'h5, rd); chk(rd, 8'h41);
      HOST.host_rd(3'h0, rd); chk(rd, 8'h77);
      $display("test compatibility receive done");

      // holding-empty and its interrupt withdrawal
      HOST.host_wr(3'h1, 8'h02);
      mpu_rd(8'hF0, rd);
      HOST.host_rd(3'h5, rd); chk(rd, 8'h60);
      irq_is(1'b1);
      // stop pulse holds the empty interrupt off for three edges; the first two are checked
      tx_stop <= 1'b1;
      @(posedge clk);
      tx_stop <= 1'b0;
      #1 chk({7'h00, host_irq}, 8'h00);
      @(posedge clk);
      #1 chk({7'h00, host_irq}, 8'h00);
      irq_is(1'b1);
      HOST.host_wr(3'h0, 8'h3C);
      repeat (2) @(posedge clk);
      #1 chk({7'h00, host_irq}, 8'h00);
      HOST.host_rd(3'h5, rd); chk(rd, 8'h40);
      $display("test holding empty done");

      // modem, timeout and power-down
      HOST.host_wr(3'h1, 8'h08);
      modem_status <= 4'h2;
      irq_is(1'b1);
      power_down <= 1'b1;
      irq_is(1'b0);
      power_down <= 1'b0;
      modem_status <= 4'h0;
      HOST.host_wr(3'h1, 8'h01);
      rx_timeout <= 1'b1;
      irq_is(1'b1);
      rx_timeout <= 1'b0;
      irq_is(1'b0);
      $display("test interrupt causes done");

      // queue mode: fill to refusal, overrun, drain with error accumulation
      restart(1'b1);
      for (int i = 0; i < 32; i++) begin
         if (i == 1)
            mpu_wr(8'hF5, 8'h04);
         mpu_wr(8'hF0, 8'(i));
      end
      #1 chk({7'h00, rx_wr_ready}, 8'h00);
      HOST.host_rd(3'h5, rd); chk(rd, 8'h81);
      mpu_wr(8'hF0, 8'hEE);
      HOST.host_rd(3'h5, rd); chk(rd, 8'h83);
      HOST.host_rd(3'h0, rd); chk(rd, 8'h00);
      HOST.host_rd(3'h5, rd); chk(rd, 8'h85);
      for (int i = 1; i < 32; i++) begin
         HOST.host_rd(3'h0, rd); chk(rd, 8'(i));
      end
      HOST.host_rd(3'h5, rd); chk(rd, 8'h04);
      HOST.host_rd(3'h5, rd); chk(rd, 8'h00);
      $display("test queue mode done");

      end_of_test();
   end
endmodule
